// File: inc/user_pin_regs.vh
`ifndef USER_PIN_REGS_VH
`define USER_PIN_REGS_VH
// special function register addresses
`define PIN_DATA_VALUE_ADDR 16'h0090
`define PIN_DIRECTION_ADDR 16'h0091
// extended register addresses of the four selector pairs
`define PIN_FUNC_PAIR0_ADDR 16'hff90
`define PIN_FUNC_PAIR1_ADDR 16'hff91
`define PIN_FUNC_PAIR2_ADDR 16'hff92
`define PIN_FUNC_PAIR3_ADDR 16'hff93
// selector field positions inside a pair register
`define SEL_EVEN_LSB 0
`define SEL_ODD_LSB 4
`define SEL_WIDTH 3
// reset values
`define DIR_RESET 8'hff
`define DATA_RESET 8'h00
`define FUNC_RESET 8'h00
// stored bits of a pair register; bits 7 and 3 are unused
`define FUNC_MASK 8'h77
// selector codes
`define SEL_COUNTER0 3'h2
`define SEL_COUNTER1 3'h3
`define SEL_INT0_TRUE 3'h4
`define SEL_INT1_TRUE 3'h5
`define SEL_INT0_INV 3'h6
`define SEL_INT1_INV 3'h7
`endif

// File: rtl/pin_resource_route.v
`timescale 1ns/1ns
`default_nettype none
`include "user_pin_regs.vh"

// ***************************************************
// per-pin resource decode
// ***************************************************
module pin_resource_route (
   // selector and synchronised level
   input wire [2:0] selCode,
   input wire pinLevel,
   // contributions to shared resources
   output reg toCounter0,
   output reg toCounter1,
   output reg toInt0,
   output reg toInt1
);

   // decode the selector; codes 0 and 1 leave the pin plain
   always @* begin
      toCounter0 = 1'b0;
      toCounter1 = 1'b0;
      toInt0 = 1'b0;
      toInt1 = 1'b0;
      case (selCode)
         `SEL_COUNTER0: toCounter0 = pinLevel;
         `SEL_COUNTER1: toCounter1 = pinLevel;
         `SEL_INT0_TRUE: toInt0 = pinLevel;
         `SEL_INT1_TRUE: toInt1 = pinLevel;
         `SEL_INT0_INV: toInt0 = ~pinLevel;
         `SEL_INT1_INV: toInt1 = ~pinLevel;
         default: toInt0 = 1'b0;
      endcase
   end

endmodule // pin_resource_route
`default_nettype wire

// File: rtl/user_pin_port.v
`timescale 1ns/1ns
`default_nettype none
`include "user_pin_regs.vh"

// How it works
// - eight pins, all inputs after reset
// - pull-ups held until direction register written
// - direction bit 0 output, 1 input
// - data register reads pins, writes output levels
// - four registers hold two selectors each
// - even pin bits 2:0, odd pin 6:4
// - selector 0 or 1 is plain pin
// - selectors 2,3 feed counter 0,1 inputs
// - selectors 4,5 feed interrupts non-inverted
// - selectors 6,7 feed interrupts inverted
// - type bit picks edge or level
// - pins sharing resource are OR-combined
// - type 1 falling edge, 0 low level
// - edge flag set on edge, cleared when serviced
module user_pin_port #(
   parameter PIN_COUNT = 8
) (
   // clock and reset
   input wire clk_sys,
   input wire reset_n,
   // core register port
   input wire [15:0] regAddr,
   input wire regWrite,
   input wire [7:0] regWdata,
   output reg [7:0] regRdata,
   // interrupt type bits and service acknowledges from the core
   input wire int0TypeSelect,
   input wire int1TypeSelect,
   input wire int0Ack,
   input wire int1Ack,
   // interrupt requests to the core
   output reg int0EdgeFlag,
   output reg int1EdgeFlag,
   output wire int0Request,
   output wire int1Request,
   // counter inputs
   output reg counter0Input,
   output reg counter1Input,
   // user pins
   input wire [PIN_COUNT-1:0] userPinIn,
   output reg [PIN_COUNT-1:0] userPinOut,
   output reg [PIN_COUNT-1:0] userPinOe,
   output reg [PIN_COUNT-1:0] userPinPullup
);

   // ***************************************************
   // registers
   // ***************************************************
   reg [PIN_COUNT-1:0] dataOut_reg; // levels for output pins
   reg [PIN_COUNT-1:0] dir_reg; // 1 = input
   reg pullEn_reg; // pull-ups live until first direction write
   reg [7:0] func_reg [0:3]; // selector pair registers
   reg [PIN_COUNT-1:0] syncA_reg; // first synchroniser stage
   reg [PIN_COUNT-1:0] syncB_reg; // second stage, the only reader of stage one
   reg int0Prev_reg; // last active-low int0 level
   reg int1Prev_reg;
   integer i;

   // write into the selector pairs; bits 7 and 3 are not stored
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (i = 0; i < 4; i = i + 1) begin
            func_reg[i] <= `FUNC_RESET;
         end
      end else if (regWrite) begin
         // one pair per address; a case keeps every compare at the bus width
         case (regAddr)
            `PIN_FUNC_PAIR0_ADDR: func_reg[0] <= regWdata & `FUNC_MASK;
            `PIN_FUNC_PAIR1_ADDR: func_reg[1] <= regWdata & `FUNC_MASK;
            `PIN_FUNC_PAIR2_ADDR: func_reg[2] <= regWdata & `FUNC_MASK;
            `PIN_FUNC_PAIR3_ADDR: func_reg[3] <= regWdata & `FUNC_MASK;
            default: ; // other addresses leave the pairs alone
         endcase
      end
   end

   // data, direction and pull-up control
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dataOut_reg <= `DATA_RESET;
         dir_reg <= `DIR_RESET;
         pullEn_reg <= 1'b1;
      end else if (regWrite) begin
         if (regAddr == `PIN_DATA_VALUE_ADDR) begin
            dataOut_reg <= regWdata[PIN_COUNT-1:0];
         end
         if (regAddr == `PIN_DIRECTION_ADDR) begin
            dir_reg <= regWdata[PIN_COUNT-1:0];
            pullEn_reg <= 1'b0;
         end
      end
   end

   // ***************************************************
   // pin side
   // ***************************************************
   // two-stage synchroniser for every pin
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         syncA_reg <= {PIN_COUNT{1'b0}};
         syncB_reg <= {PIN_COUNT{1'b0}};
      end else begin
         syncA_reg <= userPinIn;
         syncB_reg <= syncA_reg;
      end
   end

   // drive registered pin outputs; output enable follows a 0 direction bit
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         userPinOut <= {PIN_COUNT{1'b0}};
         userPinOe <= {PIN_COUNT{1'b0}};
         userPinPullup <= {PIN_COUNT{1'b1}};
      end else begin
         userPinOut <= dataOut_reg;
         userPinOe <= ~dir_reg;
         userPinPullup <= {PIN_COUNT{pullEn_reg}};
      end
   end

   // register read mux; unmapped addresses return zero
   always @* begin
      regRdata = 8'h00;
      case (regAddr)
         `PIN_DATA_VALUE_ADDR: regRdata = syncB_reg;
         `PIN_DIRECTION_ADDR: regRdata = dir_reg;
         `PIN_FUNC_PAIR0_ADDR: regRdata = func_reg[0];
         `PIN_FUNC_PAIR1_ADDR: regRdata = func_reg[1];
         `PIN_FUNC_PAIR2_ADDR: regRdata = func_reg[2];
         `PIN_FUNC_PAIR3_ADDR: regRdata = func_reg[3];
         default: regRdata = 8'h00;
      endcase
   end

   // ***************************************************
   // resource routing
   // ***************************************************
   wire [PIN_COUNT-1:0] c0Vec;
   wire [PIN_COUNT-1:0] c1Vec;
   wire [PIN_COUNT-1:0] i0Vec;
   wire [PIN_COUNT-1:0] i1Vec;

   genvar g;
   generate
      for (g = 0; g < PIN_COUNT; g = g + 1) begin : route
         // even pins use the low field, odd pins the high field
         wire [2:0] sel = (g % 2 == 1) ? func_reg[g/2][`SEL_ODD_LSB +: `SEL_WIDTH]
                               : func_reg[g/2][`SEL_EVEN_LSB +: `SEL_WIDTH];
         pin_resource_route u_route (
            .selCode(sel),
            .pinLevel(syncB_reg[g]),
            .toCounter0(c0Vec[g]),
            .toCounter1(c1Vec[g]),
            .toInt0(i0Vec[g]),
            .toInt1(i1Vec[g])
         );
      end
   endgenerate

   // combined sources, high means active
   wire int0Active = |i0Vec;
   wire int1Active = |i1Vec;

   // counter inputs are registered OR of all routed pins
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         counter0Input <= 1'b0;
         counter1Input <= 1'b0;
      end else begin
         counter0Input <= |c0Vec;
         counter1Input <= |c1Vec;
      end
   end

   // ***************************************************
   // interrupt detection
   // ***************************************************
   // the core's inputs are active low: a falling edge there is the
   // inactive-to-active step of the combined source
   wire int0Low = ~int0Active;
   wire int1Low = ~int1Active;
   wire int0Fall = int0Prev_reg & ~int0Low;
   wire int1Fall = int1Prev_reg & ~int1Low;

   // edge flags; a new edge in the ack cycle wins over the clear
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         int0Prev_reg <= 1'b1;
         int1Prev_reg <= 1'b1;
         int0EdgeFlag <= 1'b0;
         int1EdgeFlag <= 1'b0;
      end else begin
         int0Prev_reg <= int0Low;
         int1Prev_reg <= int1Low;
         if (int0TypeSelect && int0Fall) begin
            int0EdgeFlag <= 1'b1;
         end else if (int0Ack || !int0TypeSelect) begin
            int0EdgeFlag <= 1'b0;
         end
         if (int1TypeSelect && int1Fall) begin
            int1EdgeFlag <= 1'b1;
         end else if (int1Ack || !int1TypeSelect) begin
            int1EdgeFlag <= 1'b0;
         end
      end
   end

   // type bit picks latched edge or live low level
   assign int0Request = int0TypeSelect ? int0EdgeFlag : int0Active;
   assign int1Request = int1TypeSelect ? int1EdgeFlag : int1Active;

endmodule // user_pin_port
`default_nettype wire

// File: bench/pin_board_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// board side of the user pins
// ****
module pin_board_model (
   // clock and device side
   input wire logic clk_sys,
   input wire logic [7:0] userPinOut,
   input wire logic [7:0] userPinOe,
   input wire logic [7:0] userPinPullup,
   // board drivers and pin levels
   input wire logic [7:0] drv,
   input wire logic [7:0] drvEn,
   output logic [7:0] userPinIn
);
   logic [7:0] lastLevel = 8'h00; // a floating line drifts off its last level
   always @(posedge clk_sys) begin
      lastLevel <= userPinIn;
   end
   // device drive wins, then board, then pull-up, else float
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         userPinIn[i] = userPinOe[i] ? userPinOut[i] : drvEn[i] ? drv[i] :
            userPinPullup[i] ? 1'b1 : ~lastLevel[i];
      end
   end
endmodule // pin_board_model
`default_nettype wire

// File: bench/user_pin_port_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// port checker
// ****
module user_pin_port_properties #(
   parameter PIN_COUNT = 8
) (
   // clock, reset, register port
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [15:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   // interrupt 0
   input wire logic int0TypeSelect,
   input wire logic int0Ack,
   input wire logic int0EdgeFlag,
   input wire logic int0Request,
   // pins
   input wire logic [PIN_COUNT-1:0] userPinIn,
   input wire logic [PIN_COUNT-1:0] userPinOut,
   input wire logic [PIN_COUNT-1:0] userPinOe,
   input wire logic [PIN_COUNT-1:0] userPinPullup
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // pin outputs trail a write by two edges
   wire dirWr = regWrite && regAddr == 16'h0091;
   wire datWr = regWrite && regAddr == 16'h0090;
   AST_PULL_INPUT: assert property (userPinPullup == '1 |-> userPinOe == '0)
      else $error("pin driven while pulled up");
   AST_PULL_REL: assert property (dirWr |-> ##2 userPinPullup == '0)
      else $error("pull-up kept");
   AST_DIR_OE: assert property (dirWr |-> ##2 userPinOe == ~$past(regWdata, 2))
      else $error("direction wrong");
   AST_DATA_OUT: assert property (datWr |-> ##2
      (userPinOut & userPinOe) == ($past(regWdata, 2) & userPinOe)) else $error("drive wrong");
   AST_PAIR_GAP: assert property (regAddr[15:2] == 14'h3fe4 |->
      regRdata[7] == 1'b0 && regRdata[3] == 1'b0) else $error("unused bit set");
   AST_PIN_READ: assert property ($stable(userPinIn) [*3] ##0 regAddr == 16'h0090
      |-> regRdata == userPinIn) else $error("pin read wrong");
   AST_LEVEL_NOFLAG: assert property (!int0TypeSelect ##1 !int0TypeSelect
      |-> !int0EdgeFlag) else $error("flag in level mode");
   AST_FLAG_HOLD: assert property (int0EdgeFlag && !int0Ack && int0TypeSelect
      |=> int0EdgeFlag) else $error("flag lost");
   AST_REQ_EDGE: assert property (int0TypeSelect |-> int0Request == int0EdgeFlag)
      else $error("request not flag");
   cover property ($rose(int0EdgeFlag));
   cover property ($fell(userPinPullup[0]));
   cover property (datWr);
endmodule // user_pin_port_properties
bind user_pin_port user_pin_port_properties #(.PIN_COUNT(PIN_COUNT)) u_user_pin_port_properties (
   .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrite(regWrite),
   .regWdata(regWdata), .regRdata(regRdata), .int0TypeSelect(int0TypeSelect),
   .int0Ack(int0Ack), .int0EdgeFlag(int0EdgeFlag), .int0Request(int0Request),
   .userPinIn(userPinIn), .userPinOut(userPinOut), .userPinOe(userPinOe),
   .userPinPullup(userPinPullup));
`default_nettype wire

// File: bench/user_pin_port_with_resource_mux_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// user pin port bench
// ****
module user_pin_port_with_resource_mux_tb_top;
   logic clk_sys = 0, reset_n = 0, regWrite = 0, typ0 = 0, typ1 = 0, ack0 = 0, ack1 = 0;
   logic [15:0] regAddr = 16'h0000;
   logic [7:0] regWdata = 8'h00, drv = 8'h00, drvEn = 8'h00, x;
   logic [3:0] e;
   wire [7:0] rData, pOut, pOe, pPu, pIn;
   wire f0, f1, q0, q1, c0, c1;
   int miscompares = 0, n_checks = 0, cyc = 0, k, c, sel [8];
   user_pin_port u_user_pin_port (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
      .regWrite(regWrite), .regWdata(regWdata), .regRdata(rData), .int0TypeSelect(typ0),
      .int1TypeSelect(typ1), .int0Ack(ack0), .int1Ack(ack1), .int0EdgeFlag(f0),
      .int1EdgeFlag(f1), .int0Request(q0), .int1Request(q1), .counter0Input(c0),
      .counter1Input(c1), .userPinIn(pIn), .userPinOut(pOut), .userPinOe(pOe),
      .userPinPullup(pPu));
   pin_board_model u_pin_board_model (.clk_sys(clk_sys), .userPinOut(pOut), .userPinOe(pOe),
      .userPinPullup(pPu), .drv(drv), .drvEn(drvEn), .userPinIn(pIn));
   initial forever #50 clk_sys = ~clk_sys;
   // hang guard: the run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic chk(string n, logic [7:0] ex, logic [7:0] s);
      n_checks++;
      if (s !== ex) begin
         $display("BAD %s expected %h seen %h", n, ex, s);
         miscompares++;
      end
   endtask
   task automatic w(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // one write strobe, the bench model follows the selectors
   task automatic wr(logic [15:0] a, logic [7:0] d);
      w(1);
      regAddr = a;
      regWdata = d;
      regWrite = 1;
      if (a[15:2] == 14'h3fe4) begin
         sel[2 * a[1:0]] = d[2:0];
         sel[2 * a[1:0] + 1] = d[6:4];
      end
      w(1);
      regWrite = 0;
   endtask
   task automatic rd(logic [15:0] a, logic [7:0] ex);
      w(1);
      regAddr = a;
      #10 chk("rdata", ex, rData);
   endtask
   // routed levels: counter 0, counter 1, interrupt 0, interrupt 1
   function automatic logic [3:0] res(logic [7:0] p);
      res = 4'h0;
      for (int i = 0; i < 8; i++) begin
         res |= {sel[i] == 5 && p[i], sel[i] == 4 && p[i], sel[i] == 3 && p[i],
            sel[i] == 2 && p[i]};
         res |= {sel[i] == 7 && !p[i], sel[i] == 6 && !p[i], 2'b00};
      end
   endfunction
   task wrap_up();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      void'($urandom(32'ha576));
      for (k = 0; k < 8; k++) sel[k] = 0;
      w(5);
      reset_n = 1;
      chk("oe", 8'h00, pOe);
      chk("pullup", 8'hff, pPu);
      rd(16'h0091, 8'hff);
      rd(16'h0055, 8'h00);
      for (k = 0; k < 4; k++) rd(16'(16'hff90 + k), 8'h00);
      for (k = 0; k < 4; k++) begin
         x = 8'($urandom);
         wr(16'(16'hff90 + k), x);
         rd(16'(16'hff90 + k), x & 8'h77);
      end
      x = 8'($urandom);
      drv = 8'($urandom);
      drvEn = x;
      wr(16'h0091, x);
      wr(16'h0090, 8'h5a);
      chk("oe", ~x, pOe);
      chk("pullup", 8'h00, pPu);
      w(1);
      chk("out", 8'h5a & ~x, pOut & pOe);
      w(1); // the new drive level needs both synchroniser stages
      rd(16'h0090, (8'h5a & ~x) | (drv & x));
      drvEn = 8'hff;
      wr(16'h0091, 8'hff);
      for (c = 0; c < 8; c++) begin
         wr(16'hff90, {1'b0, 3'(c), 1'b0, 3'(c)});
         for (k = 0; k < 6; k++) begin
            drv = 8'($urandom);
            w(4);
            e = res(drv);
            chk("route", {4'h0, e}, {2'b00, f1, f0, q1, q0, c1, c0});
         end
      end
      for (k = 1; k < 4; k++) wr(16'(16'hff90 + k), 8'h00);
      wr(16'hff90, 8'h56);
      drv = 8'h01;
      typ0 = 1;
      typ1 = 1;
      w(4);
      chk("flags", 8'h00, {4'h0, q1, q0, f1, f0});
      drv = 8'h02;
      w(4);
      chk("flags", 8'h0f, {4'h0, q1, q0, f1, f0});
      ack1 = 1;
      w(1);
      ack1 = 0;
      w(1);
      chk("flags", 8'h05, {4'h0, q1, q0, f1, f0});
      ack0 = 1;
      typ1 = 0;
      w(1);
      ack0 = 0;
      w(1);
      chk("flags", 8'h08, {4'h0, q1, q0, f1, f0});
      wrap_up();
   end
endmodule // user_pin_port_with_resource_mux_tb_top
`default_nettype wire
